// ===== logic/wlcm_pkg.sv
package wlcm_pkg;
	// sample and position formats
	localparam int SAMPLE_W = 8;
	localparam int BIN_COUNT = 256;
	localparam int ADDR_W = 16;
	localparam int FRAC_W = 8;
	localparam int POS_W = ADDR_W + FRAC_W;
	localparam int REF_COUNT = 4;

	// register port
	localparam int REG_AW = 8;
	localparam int REG_DW = 32;
	localparam logic [REG_AW-1:0] OFS_CTRL = 8'h00;
	localparam logic [REG_AW-1:0] OFS_REF_MODE = 8'h04;
	localparam logic [REG_AW-1:0] OFS_REF_BASE = 8'h08; // four words
	localparam logic [REG_AW-1:0] OFS_COUNT = 8'h18;
	localparam logic [REG_AW-1:0] OFS_CURSOR_L = 8'h1c;
	localparam logic [REG_AW-1:0] OFS_CURSOR_R = 8'h20;
	localparam logic [REG_AW-1:0] OFS_STATUS = 8'h24;
	localparam logic [REG_AW-1:0] OFS_LEVELS = 8'h28;
	localparam logic [REG_AW-1:0] OFS_THRESH = 8'h2c;
	localparam logic [REG_AW-1:0] OFS_CROSS1 = 8'h30;
	localparam logic [REG_AW-1:0] OFS_CROSS2 = 8'h34;
	localparam logic [REG_AW-1:0] OFS_CROSS3 = 8'h38;
	localparam logic [REG_AW-1:0] OFS_TZERO = 8'h3c;
	localparam logic [REG_AW-1:0] OFS_TRIG = 8'h40;

	// control word fields
	localparam int CTRL_START = 0;
	localparam int CTRL_HIST = 1;
	localparam int CTRL_GATE = 2;

	// status word fields
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ERR = 2;
	localparam int ST_DIR = 3;
	localparam int ST_FOUND = 4; // three bits

	// reference level reset values, percent of span
	localparam logic [7:0] REF_RST_UPPER = 8'h5a;  // 90
	localparam logic [7:0] REF_RST_CENTER = 8'h32; // 50
	localparam logic [7:0] REF_RST_LOWER = 8'h0a;  // 10
	localparam logic [7:0] REF_RST_CENTER2 = 8'h32;
	localparam logic [7:0] PCT_FULL = 8'h64;       // 100
	localparam logic [7:0] HYST_DIV = 8'h0a;       // band is span / 10
	localparam logic [ADDR_W-1:0] COUNT_RST = 16'h01f4;

	// measurement sequence, gray coded along the path
	typedef enum logic [2:0] {
		WLCM_IDLE   = 3'b000,
		WLCM_CLEAR  = 3'b001,
		WLCM_PASS1  = 3'b011,
		WLCM_SCAN   = 3'b010,
		WLCM_LEVELS = 3'b110,
		WLCM_THRESH = 3'b111,
		WLCM_PASS2  = 3'b101,
		WLCM_DONE   = 3'b100
	} wlcm_state_t;

	// one crossing result
	typedef struct packed {
		logic             found;
		logic [POS_W-1:0] pos;
	} wlcm_cross_t;
endpackage

// ===== logic/wlcm_top.sv
`timescale 1ns/10ps
// Operation
// [RL1] histogram mode counts every sample code of the record in 256 bins
// [RL2] histogram splits into upper and lower parts at min-max midpoint
// [RL3] peak bin of upper part is 100% level, lower part peak is 0%
// [RL4] if midpoint bin beats a part's peak, midpoint is both levels
// [RL5] tied peak bins resolve to the bin farthest from the midpoint
// [RL6] min-max mode uses maximum as 100% and minimum as 0% level
// [RL7] a control bit selects min-max or histogram level method
// [RL8] four reference levels as percent of span or absolute codes
// [RL9] zone starts at sample 0, or left cursor when gated
// [RL10] zone ends at count minus one, or right cursor when gated
// [RL11] hysteresis band of one tenth amplitude on centre crossings
// [RL12] after a crossing, re-arm opposite edge only past the band
// [RL13] first centre crossing of either edge is taken, edge recorded
// [RL14] next opposite-edge crossing after the first is the second
// [RL15] next crossing after second with first's edge is the third
// [RL16] cycle begin and finish are fractional positions inside record
// [RL17] sample index before the trigger is kept as time reference
// [RL18] trigger fraction offset 0.0 to 1.0 sample captured on trigger
// [RL19] time zero equals pretrigger index plus fraction offset
// [RL20] per-crossing valid flags, error when any crossing is missing
// [RL21] crossing times linearly interpolated between straddling samples
module wlcm_top import wlcm_pkg::*; (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst,
	// register port
	input  wire logic [REG_AW-1:0] reg_addr,
	input  wire logic [REG_DW-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [REG_DW-1:0] reg_rdata,
	// acquisition memory, data one cycle after the address
	output logic      [ADDR_W-1:0] mem_addr,
	output logic                   mem_rd,
	input  wire logic [SAMPLE_W-1:0] mem_data,
	// trigger capture from acquisition logic
	input  wire logic              trig_event,
	input  wire logic [ADDR_W-1:0] trig_sample_idx,
	input  wire logic [FRAC_W:0]   trig_fraction,
	// status
	output logic                   meas_busy,
	output logic                   meas_done
);

	wlcm_state_t state;
	logic hist_mode;
	logic gate_en;
	logic [REF_COUNT-1:0] ref_abs;
	logic [7:0] ref_val [REF_COUNT];
	logic [ADDR_W-1:0] sample_count;
	logic [ADDR_W-1:0] cursor_l;
	logic [ADDR_W-1:0] cursor_r;
	logic start_go;
	logic [ADDR_W-1:0] last_idx;
	logic [ADDR_W-1:0] zone_start;
	logic [ADDR_W-1:0] zone_end;
	logic [ADDR_W-1:0] iss_idx;
	logic [ADDR_W-1:0] iss_end;
	logic iss_on;
	logic resp_valid;
	logic [ADDR_W-1:0] resp_idx;
	logic [ADDR_W:0] hist [BIN_COUNT];
	logic [SAMPLE_W-1:0] smin;
	logic [SAMPLE_W-1:0] smax;
	logic [SAMPLE_W-1:0] mid_code;
	logic [SAMPLE_W-1:0] bin;
	logic [ADDR_W:0] up_best;
	logic [ADDR_W:0] lo_best;
	logic [ADDR_W:0] mid_cnt;
	logic [SAMPLE_W-1:0] up_bin;
	logic [SAMPLE_W-1:0] lo_bin;
	logic [SAMPLE_W-1:0] level_hi;
	logic [SAMPLE_W-1:0] level_lo;
	logic [SAMPLE_W-1:0] amp;
	logic [SAMPLE_W-1:0] hyst;
	logic [SAMPLE_W-1:0] upper_threshold;
	logic [SAMPLE_W-1:0] center_threshold;
	logic [SAMPLE_W-1:0] lower_threshold;
	logic [SAMPLE_W-1:0] second_center_threshold;
	logic [SAMPLE_W-1:0] prev;
	logic armed_up;
	logic armed_dn;
	logic [1:0] n_found;
	logic first_crossing_direction;
	wlcm_cross_t first_crossing_time;
	wlcm_cross_t second_crossing_time;
	wlcm_cross_t third_crossing_time;
	logic [ADDR_W-1:0] pretrigger_sample_pos;
	logic [FRAC_W:0] trigger_fraction_offset;
	logic [POS_W:0] trigger_zero_pos;
	logic rise_hit;
	logic fall_hit;
	logic [POS_W-1:0] cross_pos;

	// percent of span above the low level, or the code itself
	function automatic logic [SAMPLE_W-1:0] ref_level(
		input logic is_abs,
		input logic [7:0] val,
		input logic [SAMPLE_W-1:0] lo,
		input logic [SAMPLE_W-1:0] span
	);
		logic [7:0] pct;
		logic [15:0] prod;
		pct = (val > PCT_FULL) ? PCT_FULL : val;
		prod = 16'(span * pct) / 16'(PCT_FULL);
		ref_level = is_abs ? val : SAMPLE_W'(lo + prod[7:0]);
	endfunction

	// fraction of a sample from a to the level, over the a-to-b step
	function automatic logic [FRAC_W:0] interp(
		input logic [SAMPLE_W-1:0] near,
		input logic [SAMPLE_W-1:0] far
	);
		logic [15:0] num;
		num = {near, 8'h00};
		interp = (far == 8'h00) ? 9'h100 : 9'(num / 16'(far));
	endfunction

	// an empty record length behaves as a single sample
	assign last_idx = (sample_count == '0) ? '0 : sample_count - 1'b1;
	// gated zone is clamped to the record so positions stay inside it
	assign zone_start = !gate_en ? '0 :
		(cursor_l > last_idx) ? last_idx : cursor_l; // [RL9]
	assign zone_end = !gate_en ? last_idx :
		(cursor_r > last_idx) ? last_idx : cursor_r; // [RL10]
	assign iss_end = (state == WLCM_PASS2) ? zone_end : last_idx;
	assign start_go = reg_wr && reg_addr == OFS_CTRL &&
		reg_wdata[CTRL_START] && state == WLCM_IDLE;
	assign mid_code = SAMPLE_W'(({1'b0, smin} + {1'b0, smax}) >> 1); // [RL2]

	// software settings; a start while busy is ignored
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hist_mode <= 1'b0;
			gate_en <= 1'b0;
			ref_abs <= '0;
			ref_val[0] <= REF_RST_UPPER;
			ref_val[1] <= REF_RST_CENTER;
			ref_val[2] <= REF_RST_LOWER;
			ref_val[3] <= REF_RST_CENTER2;
			sample_count <= COUNT_RST;
			cursor_l <= '0;
			cursor_r <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
				OFS_CTRL: begin
					hist_mode <= reg_wdata[CTRL_HIST]; // [RL7]
					gate_en <= reg_wdata[CTRL_GATE];
				end
				OFS_REF_MODE: ref_abs <= reg_wdata[REF_COUNT-1:0]; // [RL8]
				OFS_COUNT: sample_count <= reg_wdata[ADDR_W-1:0];
				OFS_CURSOR_L: cursor_l <= reg_wdata[ADDR_W-1:0];
				OFS_CURSOR_R: cursor_r <= reg_wdata[ADDR_W-1:0];
				default: begin
					for (int r = 0; r < REF_COUNT; r++) begin
						if (reg_addr == REG_AW'(OFS_REF_BASE + 4 * r))
							ref_val[r] <= reg_wdata[7:0];
					end
				end
			endcase
		end
	end

	// measurement sequence
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state <= WLCM_IDLE;
			bin <= '0;
		end else begin
			case (state)
				WLCM_IDLE: if (start_go) state <= WLCM_CLEAR;
				WLCM_CLEAR: state <= WLCM_PASS1;
				WLCM_PASS1: begin
					bin <= '0;
					if (resp_valid && resp_idx == last_idx)
						state <= WLCM_SCAN;
				end
				WLCM_SCAN: begin
					bin <= bin + 1'b1;
					if (bin == SAMPLE_W'(BIN_COUNT - 1))
						state <= WLCM_LEVELS;
				end
				WLCM_LEVELS: state <= WLCM_THRESH;
				WLCM_THRESH: state <= WLCM_PASS2;
				WLCM_PASS2:
					if (resp_valid && resp_idx == zone_end)
						state <= WLCM_DONE;
				WLCM_DONE: state <= WLCM_IDLE;
				default: state <= WLCM_IDLE;
			endcase
		end
	end

	// busy and done flags; done holds until the next start
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meas_busy <= 1'b0;
			meas_done <= 1'b0;
		end else begin
			meas_busy <= (state != WLCM_IDLE && state != WLCM_DONE) ||
				start_go;
			if (state == WLCM_DONE)
				meas_done <= 1'b1;
			else if (start_go)
				meas_done <= 1'b0;
		end
	end

	// memory read issue, one address per cycle, never stalled
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			iss_on <= 1'b0;
			iss_idx <= '0;
			mem_addr <= '0;
			mem_rd <= 1'b0;
		end else if (state == WLCM_CLEAR || state == WLCM_THRESH) begin
			iss_on <= 1'b1;
			iss_idx <= (state == WLCM_CLEAR) ? '0 : zone_start;
			mem_rd <= 1'b0;
		end else if (iss_on) begin
			mem_addr <= iss_idx;
			mem_rd <= 1'b1;
			iss_idx <= iss_idx + 1'b1;
			if (iss_idx == iss_end)
				iss_on <= 1'b0;
		end else begin
			mem_rd <= 1'b0;
		end
	end

	// sample return tracking
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			resp_valid <= 1'b0;
			resp_idx <= '0;
		end else begin
			resp_valid <= mem_rd;
			resp_idx <= mem_addr;
		end
	end

	// histogram and extremes over the whole record, ungated
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < BIN_COUNT; i++)
				hist[i] <= '0;
			smin <= '1;
			smax <= '0;
		end else if (state == WLCM_CLEAR) begin
			for (int i = 0; i < BIN_COUNT; i++)
				hist[i] <= '0;
			smin <= '1;
			smax <= '0;
		end else if (state == WLCM_PASS1 && resp_valid) begin
			hist[mem_data] <= hist[mem_data] + 1'b1; // [RL1]
			if (mem_data < smin)
				smin <= mem_data;
			if (mem_data > smax)
				smax <= mem_data;
		end
	end

	// bin scan; upward order lets >= keep the farthest upper tie
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			up_best <= '0;
			lo_best <= '0;
			mid_cnt <= '0;
			up_bin <= '0;
			lo_bin <= '0;
		end else if (state == WLCM_PASS1) begin
			up_best <= '0;
			lo_best <= '0;
			mid_cnt <= '0;
			up_bin <= '0;
			lo_bin <= '0;
		end else if (state == WLCM_SCAN) begin
			if (bin > mid_code) begin
				if (hist[bin] != '0 && hist[bin] >= up_best) begin // [RL5]
					up_best <= hist[bin];
					up_bin <= bin;
				end
			end else if (bin < mid_code) begin
				if (hist[bin] > lo_best) begin // [RL5]
					lo_best <= hist[bin];
					lo_bin <= bin;
				end
			end else begin
				mid_cnt <= hist[bin];
			end
		end
	end

	// 100% and 0% levels, amplitude and band
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			level_hi <= '0;
			level_lo <= '0;
			amp <= '0;
			hyst <= '0;
		end else if (state == WLCM_LEVELS) begin
			if (!hist_mode) begin
				level_hi <= smax; // [RL6]
				level_lo <= smin;
			end else if (mid_cnt > up_best || mid_cnt > lo_best) begin
				level_hi <= mid_code; // [RL4]
				level_lo <= mid_code;
			end else begin
				level_hi <= up_bin; // [RL3]
				level_lo <= lo_bin;
			end
		end else if (state == WLCM_THRESH) begin
			amp <= level_hi - level_lo;
			hyst <= (level_hi - level_lo) / HYST_DIV; // [RL11]
		end
	end

	// reference levels resolved against the derived span
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			upper_threshold <= '0;
			center_threshold <= '0;
			lower_threshold <= '0;
			second_center_threshold <= '0;
		end else if (state == WLCM_THRESH) begin
			upper_threshold <= ref_level(ref_abs[0], ref_val[0],
				level_lo, level_hi - level_lo); // [RL8]
			center_threshold <= ref_level(ref_abs[1], ref_val[1],
				level_lo, level_hi - level_lo);
			lower_threshold <= ref_level(ref_abs[2], ref_val[2],
				level_lo, level_hi - level_lo);
			second_center_threshold <= ref_level(ref_abs[3], ref_val[3],
				level_lo, level_hi - level_lo);
		end
	end

	// centre crossings with the previous sample in hand
	assign rise_hit = armed_up && prev < center_threshold &&
		mem_data >= center_threshold;
	assign fall_hit = armed_dn && prev >= center_threshold &&
		mem_data < center_threshold;
	// position of the straddling pair start plus interpolated part
	assign cross_pos = POS_W'({resp_idx - 1'b1, 8'h00}) + POS_W'(rise_hit ?
		interp(center_threshold - prev, mem_data - prev) :
		interp(prev - center_threshold, prev - mem_data)); // [RL21]

	// crossing search through the zone
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prev <= '0;
			armed_up <= 1'b0;
			armed_dn <= 1'b0;
			n_found <= '0;
			first_crossing_direction <= 1'b0;
			first_crossing_time <= '0;
			second_crossing_time <= '0;
			third_crossing_time <= '0;
		end else if (state == WLCM_THRESH) begin
			n_found <= '0;
			first_crossing_time <= '0;
			second_crossing_time <= '0;
			third_crossing_time <= '0;
		end else if (state == WLCM_PASS2 && resp_valid) begin
			prev <= mem_data;
			if (resp_idx == zone_start) begin
				// only the edge leading away from the start side is armed
				armed_up <= mem_data < center_threshold;
				armed_dn <= mem_data >= center_threshold;
			end else if (rise_hit || fall_hit) begin
				armed_up <= 1'b0; // [RL12]
				armed_dn <= 1'b0;
				case (n_found)
					2'd0: begin
						first_crossing_time <= '{1'b1, cross_pos}; // [RL13]
						first_crossing_direction <= rise_hit;
						n_found <= 2'd1;
					end
					2'd1: if (rise_hit != first_crossing_direction) begin
						second_crossing_time <= '{1'b1, cross_pos}; // [RL14]
						n_found <= 2'd2;
					end
					2'd2: if (rise_hit == first_crossing_direction) begin
						third_crossing_time <= '{1'b1, cross_pos}; // [RL15]
						n_found <= 2'd3;
					end
					default: n_found <= n_found;
				endcase
			end else begin
				if (9'(mem_data) > 9'(center_threshold) + 9'(hyst))
					armed_dn <= 1'b1; // [RL12]
				if (9'(mem_data) + 9'(hyst) < 9'(center_threshold))
					armed_up <= 1'b1; // [RL11]
			end
		end
	end

	// trigger reference captured as the trigger arrives
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pretrigger_sample_pos <= '0;
			trigger_fraction_offset <= '0;
			trigger_zero_pos <= '0;
		end else if (trig_event) begin
			pretrigger_sample_pos <= trig_sample_idx; // [RL17]
			// offsets past one sample are held at exactly 1.0
			trigger_fraction_offset <= (trig_fraction > 9'h100) ?
				9'h100 : trig_fraction; // [RL18]
			trigger_zero_pos <= {1'b0, trig_sample_idx, 8'h00} +
				(POS_W + 1)'((trig_fraction > 9'h100) ?
				9'h100 : trig_fraction); // [RL19]
		end
	end

	// read data in the cycle after the strobe only
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (!reg_rd) begin
			reg_rdata <= '0;
		end else begin
			case (reg_addr)
				OFS_CTRL: reg_rdata <= 32'({gate_en, hist_mode, 1'b0});
				OFS_REF_MODE: reg_rdata <= 32'(ref_abs);
				OFS_REF_BASE: reg_rdata <= 32'(ref_val[0]);
				OFS_REF_BASE + 8'h04: reg_rdata <= 32'(ref_val[1]);
				OFS_REF_BASE + 8'h08: reg_rdata <= 32'(ref_val[2]);
				OFS_REF_BASE + 8'h0c: reg_rdata <= 32'(ref_val[3]);
				OFS_COUNT: reg_rdata <= 32'(sample_count);
				OFS_CURSOR_L: reg_rdata <= 32'(cursor_l);
				OFS_CURSOR_R: reg_rdata <= 32'(cursor_r);
				OFS_STATUS: reg_rdata <= 32'({third_crossing_time.found,
					second_crossing_time.found, first_crossing_time.found,
					first_crossing_direction,
					meas_done && n_found != 2'd3, // [RL20]
					meas_done, meas_busy});
				OFS_LEVELS: reg_rdata <= {hyst, amp, level_lo, level_hi};
				OFS_THRESH: reg_rdata <= {second_center_threshold,
					lower_threshold, center_threshold, upper_threshold};
				// cycle begin and finish are the first and third crossings
				OFS_CROSS1: reg_rdata <= 32'(first_crossing_time); // [RL16]
				OFS_CROSS2: reg_rdata <= 32'(second_crossing_time);
				OFS_CROSS3: reg_rdata <= 32'(third_crossing_time); // [RL16]
				OFS_TZERO: reg_rdata <= 32'(trigger_zero_pos);
				OFS_TRIG: reg_rdata <= {7'h00, trigger_fraction_offset,
					pretrigger_sample_pos};
				default: reg_rdata <= '0;
			endcase
		end
	end

endmodule // wlcm_top

// ===== verification/wlcm_top_props.sv
`timescale 1ns/10ps
module wlcm_top_props import wlcm_pkg::*; (
	// clock and reset
	input wire logic                clk_sys,
	input wire logic                rst,
	// register port
	input wire logic [REG_AW-1:0]   reg_addr,
	input wire logic [REG_DW-1:0]   reg_wdata,
	input wire logic                reg_wr,
	input wire logic                reg_rd,
	input wire logic [REG_DW-1:0]   reg_rdata,
	// acquisition memory
	input wire logic [ADDR_W-1:0]   mem_addr,
	input wire logic                mem_rd,
	input wire logic [SAMPLE_W-1:0] mem_data,
	// trigger and status
	input wire logic                trig_event,
	input wire logic [ADDR_W-1:0]   trig_sample_idx,
	input wire logic [FRAC_W:0]     trig_fraction,
	input wire logic                meas_busy,
	input wire logic                meas_done
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// start request as written, without the design's idle check
	logic start_wr;
	assign start_wr = reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTRL_START];

	a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data seen outside the answer cycle");
	a_fetch_busy: assert property (mem_rd |-> meas_busy)
		else $error("sample fetch while idle");
	a_addr_step: assert property (mem_rd && $past(mem_rd) |->
		mem_addr == $past(mem_addr) + 16'h0001)
		else $error("sample addresses not consecutive");
	a_start_busy: assert property (start_wr && !meas_busy |=>
		meas_busy && !meas_done)
		else $error("start did not raise busy");
	a_flags_excl: assert property (!(meas_busy && meas_done))
		else $error("busy and done together");
	a_done_holds: assert property (meas_done && !start_wr |=> meas_done)
		else $error("done dropped without a new start");
	a_done_rise: assert property ($rose(meas_done) |-> $past(meas_busy))
		else $error("done without a measurement");
	a_first_fetch: assert property ($rose(meas_busy) |->
		##[1:4] (mem_rd && mem_addr == 16'h0000))
		else $error("record scan does not begin at sample zero");
	a_trig_read: assert property (trig_event && trig_fraction <= 9'h100
		##1 reg_rd && reg_addr == OFS_TRIG |=>
		reg_rdata[24:0] == {$past(trig_fraction, 2), $past(trig_sample_idx, 2)})
		else $error("trigger capture not readable next cycle");

	// main scenarios
	c_hist_start: cover property (start_wr && reg_wdata[CTRL_HIST]);
	c_gate_start: cover property (start_wr && reg_wdata[CTRL_GATE]);
	c_finish: cover property ($rose(meas_done));
endmodule // wlcm_top_props

bind wlcm_top wlcm_top_props u_props (
	.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd),
	.mem_data(mem_data), .trig_event(trig_event),
	.trig_sample_idx(trig_sample_idx), .trig_fraction(trig_fraction),
	.meas_busy(meas_busy), .meas_done(meas_done)
);

// ===== verification/wlcm_acq_mem.sv
`timescale 1ns/10ps
module wlcm_acq_mem import wlcm_pkg::*; (
	// clock
	input wire logic                clk_sys,
	// fetch port
	input wire logic [ADDR_W-1:0]   mem_addr,
	input wire logic                mem_rd,
	output logic     [SAMPLE_W-1:0] mem_data
);
	// record store, loaded by the bench before each start except the min-max rerun, which reuses the tied-peak record
	logic [SAMPLE_W-1:0] samp [0:255];

	initial mem_data = 8'h5a;

	// answer one cycle after the fetch; between fetches the data
	// toggles so a design sampling at the wrong cycle sees garbage
	always @(posedge clk_sys) begin
		if (mem_rd)
			mem_data <= samp[mem_addr[7:0]];
		else
			mem_data <= ~mem_data;
	end
endmodule // wlcm_acq_mem

// ===== verification/tb_top.sv
`timescale 1ns/10ps
module tb_top import wlcm_pkg::*; ;
	// design ports
	logic                clk_sys = 1'b0;
	logic                rst = 1'b1;
	logic [REG_AW-1:0]   reg_addr = '0;
	logic [REG_DW-1:0]   reg_wdata = '0;
	logic                reg_wr = 1'b0;
	logic                reg_rd = 1'b0;
	logic [REG_DW-1:0]   reg_rdata;
	logic [ADDR_W-1:0]   mem_addr;
	logic                mem_rd;
	logic [SAMPLE_W-1:0] mem_data;
	logic                trig_event = 1'b0;
	logic [ADDR_W-1:0]   trig_sample_idx = '0;
	logic [FRAC_W:0]     trig_fraction = '0;
	logic                meas_busy;
	logic                meas_done;
	int                  n_fail = 0;
	int                  n_compared = 0;
	logic [REG_DW-1:0]   v;

	always #5 clk_sys = ~clk_sys;

	wlcm_top DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_data(mem_data), .trig_event(trig_event),
		.trig_sample_idx(trig_sample_idx), .trig_fraction(trig_fraction),
		.meas_busy(meas_busy), .meas_done(meas_done));

	wlcm_acq_mem mem (.clk_sys(clk_sys), .mem_addr(mem_addr),
		.mem_rd(mem_rd), .mem_data(mem_data));

	// closing report, reached from the end and from any timeout
	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		// idle edge: the strobe is never driven twice in one step, and a
		// start has cleared the old done flag before anyone polls it
		@(posedge clk_sys);
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rchk(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		v = reg_rdata;
		@(posedge clk_sys);
		chk(v, e);
	endtask

	// start and wait for done, bounded
	task automatic run(input logic [REG_DW-1:0] ctrl);
		int i;
		wr(OFS_CTRL, ctrl | 32'h1);
		for (i = 0; i < 3000 && meas_done !== 1'b1; i++)
			@(negedge clk_sys);
		@(posedge clk_sys);
		if (i == 3000) begin
			n_fail++;
			give_verdict();
		end
	endtask

	// square wave with a glitch on the falling edge
	task automatic fill_square();
		for (int i = 0; i < 32; i++)
			mem.samp[i] = (i % 16 >= 4 && i % 16 < 12) ? 8'hdc : 8'h14;
		mem.samp[12] = 8'h6e;
		mem.samp[13] = 8'h82;
	endtask

	task automatic trig(input logic [8:0] f, input logic [31:0] tz,
		input logic [31:0] tp);
		trig_event <= 1'b1;
		trig_sample_idx <= 16'h0123;
		trig_fraction <= f;
		@(posedge clk_sys);
		trig_event <= 1'b0;
		rchk(OFS_TRIG, tp);
		rchk(OFS_TZERO, tz);
	endtask

	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		// reset state of the settings
		rchk(OFS_CTRL, 32'h0);
		rchk(OFS_REF_MODE, 32'h0);
		for (int k = 0; k < 4; k++)
			rchk(OFS_REF_BASE + 8'(4 * k), {24'h0, k == 0 ? 8'h5a :
				k == 2 ? 8'h0a : 8'h32});
		rchk(OFS_COUNT, 32'h1f4);
		rchk(OFS_STATUS, 32'h0);
		rchk(8'h80, 32'h0);
		$display("test reset values done");

		// min-max levels and three alternating crossings
		wr(OFS_COUNT, 32'h20);
		fill_square();
		run(32'h0);
		rchk(OFS_LEVELS, 32'h14c814dc);
		rchk(OFS_THRESH, 32'h782878c8);
		rchk(OFS_CROSS1, 32'h1000380);
		rchk(OFS_CROSS2, 32'h1000be8);
		rchk(OFS_CROSS3, 32'h1001380);
		rchk(OFS_STATUS, 32'h7a);
		$display("test min-max crossings done");

		// tied peaks, then the same record by min-max
		for (int i = 0; i < 32; i++)
			mem.samp[i] = i < 10 ? 8'hdc : i < 18 ? 8'hc8 : i < 25 ? 8'h14 : 8'h1e;
		mem.samp[0] = 8'h00;
		mem.samp[1] = 8'hff;
		run(32'h2);
		rchk(OFS_CTRL, 32'h2);
		rchk(OFS_LEVELS, 32'h14c814dc);
		run(32'h0);
		rchk(OFS_LEVELS, 32'h19ff00ff);
		$display("test histogram ties done");

		// midpoint bin dominates both parts
		for (int i = 0; i < 32; i++)
			mem.samp[i] = 8'h64;
		mem.samp[0] = 8'h00;
		mem.samp[1] = 8'hc8;
		run(32'h2);
		rchk(OFS_LEVELS, 32'h00006464);
		$display("test midpoint level done");

		// gated zone, absolute centre, clamped upper percentage
		fill_square();
		wr(OFS_REF_MODE, 32'h2);
		wr(OFS_REF_BASE, 32'h96);
		wr(OFS_REF_BASE + 8'h04, 32'h46);
		wr(OFS_CURSOR_L, 32'h6);
		wr(OFS_CURSOR_R, 32'h12);
		run(32'h4);
		rchk(OFS_THRESH, 32'h782846dc);
		rchk(OFS_CROSS1, 32'h1000d8b);
		rchk(OFS_STATUS, 32'h16);
		$display("test gated zone done");

		// trigger reference capture, in range and clamped
		trig(9'h080, 32'h12380, 32'h0800123);
		trig(9'h1ff, 32'h12400, 32'h1000123);
		$display("test trigger reference done");
		give_verdict();
	end
endmodule // tb_top
